// >>> hw/byte_fifo.sv
`timescale 1ns/10ps
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr_ff;
	logic [PW-1:0] rd_ptr_ff;
	logic [PW:0] count_ff;
	logic [PW:0] nxt_count;
	logic full_ff;
	logic empty_ff;
	logic push;
	logic pop;

	// handshakes on both sides
	assign push = in_valid & ~full_ff;
	assign pop = out_ready & ~empty_ff;
	assign in_ready = ~full_ff;
	assign out_valid = ~empty_ff;
	assign out_data = mem[rd_ptr_ff];

	// occupancy after this cycle
	always_comb begin
		nxt_count = count_ff;
		if (push & ~pop) begin
			nxt_count = count_ff + (PW+1)'(1);
		end else if (pop & ~push) begin
			nxt_count = count_ff - (PW+1)'(1);
		end
	end

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// pointers, count and registered full / empty
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			full_ff <= 1'b0;
			empty_ff <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);
			end
			count_ff <= nxt_count;
			full_ff <= (nxt_count == (PW+1)'(DEPTH));
			empty_ff <= (nxt_count == '0);
		end
	end

endmodule

// >>> hw/parallel_port.sv
`timescale 1ns/10ps
module parallel_port (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic CFG_ASYNC_SEL,
	input wire logic BB_ENABLE,
	input wire logic [pport_pkg::DATA_W-1:0] BB_DIR_MASK,
	input wire logic REMOTE_WAKE_EN,
	input wire logic POWERED_OK_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic FLUSH_WAKE_N,
	input wire logic [pport_pkg::DATA_W-1:0] PARALLEL_DATA_BUS_IN,
	output logic [pport_pkg::DATA_W-1:0] PARALLEL_DATA_BUS_OUT,
	output logic [pport_pkg::DATA_W-1:0] PARALLEL_DATA_BUS_OE,
	output logic RX_DATA_AVAIL_N_OUT,
	output logic RX_DATA_AVAIL_N_OE,
	output logic TX_SPACE_AVAIL_N_OUT,
	output logic TX_SPACE_AVAIL_N_OE,
	output logic PIN_UPDATE_PULSE_N,
	output logic PIN_SAMPLE_PULSE_N,
	input wire logic [pport_pkg::DATA_W-1:0] RX_IN_DATA,
	input wire logic RX_IN_VALID,
	output logic RX_IN_READY,
	output logic [pport_pkg::DATA_W-1:0] TX_OUT_DATA,
	output logic TX_OUT_VALID,
	input wire logic TX_OUT_READY,
	output logic SEND_NOW,
	output logic RESUME_REQ
);
	import pport_pkg::*;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	port_mode_t mode_ff, nxt_mode;
	bb_state_t bb_state_ff;
	logic rd_s1_ff, rd_s2_ff, rd_prev_ff;
	logic wr_s1_ff, wr_s2_ff, wr_prev_ff;
	logic wk_s1_ff, wk_s2_ff, wk_prev_ff;
	logic [DATA_W-1:0] din_s1_ff, din_s2_ff;
	logic [DATA_W-1:0] data_out_ff, data_oe_ff, bb_out_ff;
	logic [DATA_W-1:0] rx_out_data, tx_push_data;
	logic rd_fall, rd_rise, wr_fall, wake_fall, async_on, bb_on;
	logic rd_took_ff, rd_gap_ff, rx_avail_n_ff, tx_space_n_ff, flags_oe_ff;
	logic upd_n_ff, smp_n_ff, send_now_ff, resume_ff;
	logic [STB_CNT_W-1:0] stb_cnt_ff;
	logic rx_out_valid, rx_pop, tx_in_ready, tx_push;

	assign async_on = (mode_ff == MODE_ASYNC);
	assign bb_on = (mode_ff == MODE_BITBANG);

	// ----------------------------------------------------------------
	// buffers
	// ----------------------------------------------------------------
	// receive path: usb engine toward the pins
	byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(SYS_CLK),
		.rst(RST),
		.in_data(RX_IN_DATA),
		.in_valid(RX_IN_VALID),
		.in_ready(RX_IN_READY),
		.out_data(rx_out_data),
		.out_valid(rx_out_valid),
		.out_ready(rx_pop)
	);
	// transmit path: pins toward the usb engine
	byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(SYS_CLK),
		.rst(RST),
		.in_data(tx_push_data),
		.in_valid(tx_push),
		.in_ready(tx_in_ready),
		.out_data(TX_OUT_DATA),
		.out_valid(TX_OUT_VALID),
		.out_ready(TX_OUT_READY)
	);

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	// two flops on every pin input, edges taken on the second stage
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rd_s1_ff <= 1'b1;
			rd_s2_ff <= 1'b1;
			rd_prev_ff <= 1'b1;
			wr_s1_ff <= 1'b1;
			wr_s2_ff <= 1'b1;
			wr_prev_ff <= 1'b1;
			wk_s1_ff <= 1'b1;
			wk_s2_ff <= 1'b1;
			wk_prev_ff <= 1'b1;
			din_s1_ff <= BYTE_ZERO;
			din_s2_ff <= BYTE_ZERO;
		end else begin
			rd_s1_ff <= RD_N;
			rd_s2_ff <= rd_s1_ff;
			rd_prev_ff <= rd_s2_ff;
			wr_s1_ff <= WR_N;
			wr_s2_ff <= wr_s1_ff;
			wr_prev_ff <= wr_s2_ff;
			wk_s1_ff <= FLUSH_WAKE_N;
			wk_s2_ff <= wk_s1_ff;
			wk_prev_ff <= wk_s2_ff;
			din_s1_ff <= PARALLEL_DATA_BUS_IN;
			din_s2_ff <= din_s1_ff;
		end
	end

	// strobe edges, no interface clock involved
	assign rd_fall = rd_prev_ff & ~rd_s2_ff;
	assign rd_rise = ~rd_prev_ff & rd_s2_ff;
	assign wr_fall = wr_prev_ff & ~wr_s2_ff;
	assign wake_fall = wk_prev_ff & ~wk_s2_ff;

	// ----------------------------------------------------------------
	// mode selection
	// ----------------------------------------------------------------
	// host command wins; async fifo only when configuration selects it
	assign nxt_mode = BB_ENABLE ? MODE_BITBANG
		: (CFG_ASYNC_SEL ? MODE_ASYNC : MODE_IDLE);
	// mode changes only with no read or bit-bang cycle in flight
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			mode_ff <= MODE_IDLE;
		end else if (!rd_took_ff && bb_state_ff == BB_IDLE) begin
			mode_ff <= nxt_mode;
		end
	end

	// ----------------------------------------------------------------
	// buffer handshakes
	// ----------------------------------------------------------------
	// pop on read release in async mode, on write start in bit-bang
	assign rx_pop = (async_on & rd_rise & rd_took_ff)
		| (bb_on & bb_state_ff == BB_IDLE & rx_out_valid);
	// push on write strobe fall, or pin sample in bit-bang
	assign tx_push = (async_on & wr_fall & ~tx_space_n_ff)
		| (bb_state_ff == BB_SAMPLE & tx_in_ready);
	assign tx_push_data = din_s2_ff;

	// ----------------------------------------------------------------
	// async fifo read side
	// ----------------------------------------------------------------
	// remembers that the current low read strobe took a byte
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rd_took_ff <= 1'b0;
		end else if (async_on && rd_fall && !rx_avail_n_ff) begin
			rd_took_ff <= 1'b1;
		end else if (rd_rise || !async_on) begin
			rd_took_ff <= 1'b0;
		end
	end
	// one cycle guard after a read so the flag is seen high
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rd_gap_ff <= 1'b0;
		end else begin
			rd_gap_ff <= rd_rise;
		end
	end
	// data-available flag
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rx_avail_n_ff <= 1'b1;
		end else if (!async_on) begin
			rx_avail_n_ff <= 1'b1;
		end else if (rd_rise) begin
			rx_avail_n_ff <= 1'b1;
		end else if (rd_s2_ff && !rd_gap_ff) begin
			rx_avail_n_ff <= ~rx_out_valid;
		end
	end

	// ----------------------------------------------------------------
	// async fifo write side
	// ----------------------------------------------------------------
	// space flag follows buffer room, raised for the cycle of a capture
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			tx_space_n_ff <= 1'b1;
		end else if (!async_on || tx_push) begin
			tx_space_n_ff <= 1'b1;
		end else begin
			tx_space_n_ff <= ~tx_in_ready;
		end
	end
	// flag enables: released in reset, driven in async mode
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			flags_oe_ff <= 1'b0;
		end else begin
			flags_oe_ff <= async_on;
		end
	end

	// ----------------------------------------------------------------
	// data bus drive
	// ----------------------------------------------------------------
	// async: drive head byte while read low; bit-bang: held latch
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			data_out_ff <= BYTE_ZERO;
			data_oe_ff <= BYTE_ZERO;
		end else if (async_on) begin
			if (rd_fall && !rx_avail_n_ff) begin
				data_out_ff <= rx_out_data;
				data_oe_ff <= BYTE_ONES;
			end else if (rd_rise || !rd_took_ff) begin
				data_oe_ff <= BYTE_ZERO;
			end
		end else if (bb_on) begin
			data_out_ff <= rx_pop ? rx_out_data : bb_out_ff;
			data_oe_ff <= (bb_state_ff == BB_IDLE && !BB_ENABLE) ? BYTE_ZERO : BB_DIR_MASK;
		end else begin
			data_oe_ff <= BYTE_ZERO;
		end
	end

	// ----------------------------------------------------------------
	// bit-bang sequencer
	// ----------------------------------------------------------------
	// write pins, pulse update strobe, sample, pulse sample strobe
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			bb_state_ff <= BB_IDLE;
			stb_cnt_ff <= STB_ZERO;
			upd_n_ff <= 1'b1;
			smp_n_ff <= 1'b1;
		end else begin
			case (bb_state_ff)
				BB_IDLE: begin
					if (rx_pop && bb_on) begin
						upd_n_ff <= 1'b0;
						stb_cnt_ff <= STB_ZERO;
						bb_state_ff <= BB_WSTB;
					end
				end
				BB_WSTB: begin
					if (stb_cnt_ff == STB_LAST) begin
						upd_n_ff <= 1'b1;
						bb_state_ff <= BB_SAMPLE;
					end else begin
						stb_cnt_ff <= stb_cnt_ff + 3'h1;
					end
				end
				BB_SAMPLE: begin
					if (tx_in_ready) begin
						smp_n_ff <= 1'b0;
						stb_cnt_ff <= STB_ZERO;
						bb_state_ff <= BB_RSTB;
					end
				end
				BB_RSTB: begin
					if (stb_cnt_ff == STB_LAST) begin
						smp_n_ff <= 1'b1;
						bb_state_ff <= BB_IDLE;
					end else begin
						stb_cnt_ff <= stb_cnt_ff + 3'h1;
					end
				end
				default: begin
					bb_state_ff <= BB_IDLE;
				end
			endcase
		end
	end
	// output latch, changed only by a host write
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			bb_out_ff <= BYTE_ZERO;
		end else if (bb_on && rx_pop) begin
			bb_out_ff <= rx_out_data;
		end
	end

	// ----------------------------------------------------------------
	// flush / wake
	// ----------------------------------------------------------------
	// low pulse: resume when suspended with remote wake enabled, send immediately when powered
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			send_now_ff <= 1'b0;
			resume_ff <= 1'b0;
		end else begin
			resume_ff <= wake_fall & POWERED_OK_N & REMOTE_WAKE_EN;
			send_now_ff <= wake_fall & ~POWERED_OK_N;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign PARALLEL_DATA_BUS_OUT = data_out_ff;
	assign PARALLEL_DATA_BUS_OE = data_oe_ff;
	assign RX_DATA_AVAIL_N_OUT = rx_avail_n_ff;
	assign RX_DATA_AVAIL_N_OE = flags_oe_ff;
	assign TX_SPACE_AVAIL_N_OUT = tx_space_n_ff;
	assign TX_SPACE_AVAIL_N_OE = flags_oe_ff;
	assign PIN_UPDATE_PULSE_N = upd_n_ff;
	assign PIN_SAMPLE_PULSE_N = smp_n_ff;
	assign SEND_NOW = send_now_ff;
	assign RESUME_REQ = resume_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);

	a_edge_only_xfer: assert property ((async_on && tx_push) |-> wr_fall)
		else $error("transfer without a write strobe fall");
	a_bus_drive_rd: assert property ((async_on && data_oe_ff != BYTE_ZERO) |-> !rd_prev_ff)
		else $error("data bus driven while read strobe high");
	a_avail_has_byte: assert property ((async_on && !rx_avail_n_ff) |-> rx_out_valid)
		else $error("data-available low with empty buffer");
	a_avail_rise_rd: assert property ((async_on && rd_rise) |=> rx_avail_n_ff [*2])
		else $error("data-available not high after read");
	a_flags_float: assert property ($rose(flags_oe_ff) |-> $past(async_on))
		else $error("flags driven outside async mode");
	a_space_room: assert property ((!tx_space_n_ff) |-> $past(tx_in_ready))
		else $error("space flag low without buffer room");
	a_rd_byte_out: assert property ((async_on && rd_fall && !rx_avail_n_ff) |=>
		(data_out_ff == $past(rx_out_data) && data_oe_ff == BYTE_ONES))
		else $error("read did not present head byte");
	a_rd_advance: assert property ((async_on && rd_rise && rd_took_ff) |-> rx_pop)
		else $error("buffer not advanced on read release");
	a_wr_capture: assert property ((async_on && wr_fall && !tx_space_n_ff) |->
		(tx_push && tx_push_data == din_s2_ff))
		else $error("write strobe fall not captured");
	a_wake_resume: assert property ((wake_fall && POWERED_OK_N && REMOTE_WAKE_EN) |=>
		(RESUME_REQ && !SEND_NOW))
		else $error("no resume request");
	a_wake_flush: assert property ((wake_fall && !POWERED_OK_N) |=> (SEND_NOW && !RESUME_REQ))
		else $error("no send-immediate");
	a_mode_async: assert property ($rose(async_on) |-> $past(CFG_ASYNC_SEL && !BB_ENABLE))
		else $error("async mode without configuration");
	a_update_pulse: assert property ($fell(upd_n_ff) |-> $past(rx_pop && bb_on))
		else $error("update strobe without host write");
	a_sample_rise: assert property ($rose(smp_n_ff) |-> $past(bb_state_ff == BB_RSTB))
		else $error("sample strobe rose out of sequence");
	a_bb_hold: assert property ((bb_on && !$past(rx_pop)) |-> $stable(bb_out_ff))
		else $error("bit-bang output changed without write");

	c_async_read: cover property (async_on && rd_rise && rd_took_ff);
	c_async_write: cover property (async_on && tx_push);
	c_bb_cycle: cover property ($rose(smp_n_ff) && bb_on);
	c_tx_full: cover property (async_on && !tx_in_ready);

endmodule

// >>> hw/pport_pkg.sv
package pport_pkg;

	// ----------------------------------------------------------------
	// widths and depths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int STROBE_NS = 16; // low time of the bit-bang strobes
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STB_CNT_W = 3;
	localparam logic [STB_CNT_W-1:0] STB_LAST = 3'(STROBE_CYC - 1);
	localparam logic [STB_CNT_W-1:0] STB_ZERO = 3'h0;

	// ----------------------------------------------------------------
	// byte constants: reset value and full drive enable
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;

	// ----------------------------------------------------------------
	// modes and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_ASYNC = 2'b01,
		MODE_BITBANG = 2'b10
	} port_mode_t;

	typedef enum logic [1:0] {
		BB_IDLE = 2'b00,
		BB_WSTB = 2'b01,
		BB_SAMPLE = 2'b10,
		BB_RSTB = 2'b11
	} bb_state_t;

endpackage

// >>> verif/ext_controller.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// external controller on the strobe side of the parallel port
// ----------------------------------------------------------------
module ext_controller (
	input wire logic clk,
	input wire logic rx_avail_n,
	input wire logic tx_space_n,
	input wire logic [7:0] pins,
	output logic rd_n,
	output logic wr_n,
	output logic [7:0] drv_data
);
	// strobes idle high; the released bus shows a changing level, never the last value
	initial begin
		rd_n = 1'b1;
		wr_n = 1'b1;
		drv_data = 8'h00;
	end

	// pin levels for bit-bang inputs
	task automatic set_pins(input logic [7:0] v);
		drv_data = v;
	endtask

	// one read; starts only while the data flag is low, then waits for it to rise
	task automatic read_byte(output logic [7:0] got, output bit ok, output bit rose);
		int w;
		w = 0;
		ok = 1'b0;
		rose = 1'b0;
		got = 8'h00;
		while (rx_avail_n !== 1'b0 && w < 200) begin
			@(posedge clk);
			#1;
			w++;
		end
		if (rx_avail_n === 1'b0) begin
			ok = 1'b1;
			rd_n = 1'b0;
			repeat (6) @(posedge clk);
			#1;
			got = pins;
			rd_n = 1'b1;
			for (w = 0; w < 10 && !rose; w++) begin
				@(posedge clk);
				#1;
				rose = (rx_avail_n === 1'b1);
			end
		end
	endtask

	// one write; data set a cycle before the fall and held three cycles after the rise
	task automatic write_byte(input logic [7:0] b, output bit ok);
		int w;
		w = 0;
		while (tx_space_n !== 1'b0 && w < 200) begin
			@(posedge clk);
			#1;
			w++;
		end
		ok = (tx_space_n === 1'b0);
		if (ok) begin
			drv_data = b;
			@(posedge clk);
			#1 wr_n = 1'b0;
			repeat (5) @(posedge clk);
			#1 wr_n = 1'b1;
			repeat (3) @(posedge clk);
			#1 drv_data = ~b;
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
endmodule

// >>> verif/parallel_port_tb.sv
`timescale 1ns/10ps
module parallel_port_tb;
	import pport_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_async_sel = 1'b1;
	logic bb_enable = 1'b0;
	logic [DATA_W-1:0] bb_dir_mask = 8'h0f;
	logic remote_wake_en = 1'b0;
	logic powered_ok_n = 1'b0;
	logic flush_wake_n = 1'b1;
	logic [DATA_W-1:0] rx_in_data = 8'h00;
	logic rx_in_valid = 1'b0;
	logic tx_out_ready = 1'b0;
	logic rd_n, wr_n, rx_out, rx_oe, tx_out, tx_oe, upd_n, smp_n;
	logic rx_in_ready, tx_out_valid, send_now, resume_req;
	logic [DATA_W-1:0] drv_data, bus_out, bus_oe, tx_out_data;
	wire logic [DATA_W-1:0] pins;
	wire logic rx_flag_n, tx_flag_n;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;

	// ----------------------------------------------------------------
	// wire levels: driven bits win, flags pulled up when undriven
	// ----------------------------------------------------------------
	assign pins = (bus_oe & bus_out) | (~bus_oe & drv_data);
	assign rx_flag_n = rx_oe ? rx_out : 1'b1;
	assign tx_flag_n = tx_oe ? tx_out : 1'b1;

	always #2 sys_clk = ~sys_clk;

	parallel_port dut (.SYS_CLK(sys_clk), .RST(rst), .CFG_ASYNC_SEL(cfg_async_sel),
		.BB_ENABLE(bb_enable), .BB_DIR_MASK(bb_dir_mask), .REMOTE_WAKE_EN(remote_wake_en),
		.POWERED_OK_N(powered_ok_n), .RD_N(rd_n), .WR_N(wr_n), .FLUSH_WAKE_N(flush_wake_n),
		.PARALLEL_DATA_BUS_IN(pins), .PARALLEL_DATA_BUS_OUT(bus_out),
		.PARALLEL_DATA_BUS_OE(bus_oe), .RX_DATA_AVAIL_N_OUT(rx_out), .RX_DATA_AVAIL_N_OE(rx_oe),
		.TX_SPACE_AVAIL_N_OUT(tx_out), .TX_SPACE_AVAIL_N_OE(tx_oe), .PIN_UPDATE_PULSE_N(upd_n),
		.PIN_SAMPLE_PULSE_N(smp_n), .RX_IN_DATA(rx_in_data), .RX_IN_VALID(rx_in_valid),
		.RX_IN_READY(rx_in_ready), .TX_OUT_DATA(tx_out_data), .TX_OUT_VALID(tx_out_valid),
		.TX_OUT_READY(tx_out_ready), .SEND_NOW(send_now), .RESUME_REQ(resume_req));

	ext_controller ctl (.clk(sys_clk), .rx_avail_n(rx_flag_n), .tx_space_n(tx_flag_n),
		.pins(pins), .rd_n(rd_n), .wr_n(wr_n), .drv_data(drv_data));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic push_rx(input logic [7:0] b);
		int w;
		for (w = 0; w < 100 && rx_in_ready !== 1'b1; w++) tick(1);
		rx_in_data = b;
		rx_in_valid = 1'b1;
		tick(1);
		rx_in_valid = 1'b0;
		tick(1);
	endtask

	task automatic pop_tx(input logic [7:0] exp);
		int w;
		for (w = 0; w < 100 && tx_out_valid !== 1'b1; w++) tick(1);
		chk8("transmit buffer byte", exp, tx_out_data);
		tx_out_ready = 1'b1;
		tick(1);
		tx_out_ready = 1'b0;
		tick(1);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_mode();
		cfg_async_sel = 1'b0;
		tick(8);
		chk1("data flag enable off mode", 1'b0, rx_oe);
		chk1("space flag enable off mode", 1'b0, tx_oe);
		cfg_async_sel = 1'b1;
		tick(8);
		chk1("data flag enable in mode", 1'b1, rx_oe);
	endtask

	task automatic t_read();
		logic [7:0] exp [3] = '{8'ha1, 8'hb2, 8'h3c};
		logic [7:0] got;
		bit ok;
		bit rose;
		for (int i = 0; i < 3; i++) push_rx(exp[i]);
		chk1("receive buffer room", 1'b1, rx_in_ready);
		tick(6);
		for (int i = 0; i < 3; i++) begin
			ctl.read_byte(got, ok, rose);
			chk1("read taken", 1'b1, ok);
			chk8("read byte", exp[i], got);
			chk1("data flag rose", 1'b1, rose);
		end
		tick(8);
		chk1("data flag empty", 1'b1, rx_flag_n);
		chk8("bus enable idle", 8'h00, bus_oe);
	endtask

	task automatic t_write();
		bit ok;
		for (int i = 0; i < 9; i++) begin
			ctl.write_byte(8'h10 + 8'(i * 17), ok);
			chk1("write taken", (i < 8) ? 1'b1 : 1'b0, ok);
		end
		chk8("bus enable during writes", 8'h00, bus_oe);
		for (int i = 0; i < 8; i++) pop_tx(8'h10 + 8'(i * 17));
		tick(4);
		chk1("space flag after drain", 1'b0, tx_flag_n);
	endtask

	task automatic t_flush();
		for (int c = 0; c < 3; c++) begin
			logic sn;
			logic rr;
			powered_ok_n = (c != 0);
			remote_wake_en = (c == 1);
			tick(2);
			sn = 1'b0;
			rr = 1'b0;
			flush_wake_n = 1'b0;
			for (int k = 0; k < 14; k++) begin
				tick(1);
				if (k == 2) flush_wake_n = 1'b1;
				sn = sn | send_now;
				rr = rr | resume_req;
			end
			chk1("flush request", (c == 0) ? 1'b1 : 1'b0, sn);
			chk1("resume request", (c == 1) ? 1'b1 : 1'b0, rr);
		end
		powered_ok_n = 1'b0;
	endtask

	task automatic t_bitbang();
		int w;
		int n;
		ctl.set_pins(8'hc3);
		bb_enable = 1'b1;
		tick(8);
		push_rx(8'h5a);
		for (w = 0; w < 50 && upd_n !== 1'b0; w++) tick(1);
		chk1("update strobe low", 1'b0, upd_n);
		chk8("pin drive enable", 8'h0f, bus_oe);
		chk8("output pins", 8'h0a, pins & 8'h0f);
		for (n = 0; n < 20 && upd_n === 1'b0; n++) tick(1);
		chk8("update strobe width", 8'h04, 8'(n));
		for (w = 0; w < 50 && smp_n !== 1'b0; w++) tick(1);
		for (w = 0; w < 20 && smp_n === 1'b0; w++) tick(1);
		chk1("sample strobe rose", 1'b1, smp_n);
		chk1("sample forwarded", 1'b1, tx_out_valid);
		ctl.set_pins(8'h3c);
		tick(20);
		chk8("output pins held", 8'h0a, pins & 8'h0f);
		pop_tx(8'hca);
		bb_enable = 1'b0;
		tick(8);
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("[ERR] cycle limit reached");
			wrap_up();
		end
	end

	initial begin
		tick(5);
		chk1("data flag enable in reset", 1'b0, rx_oe);
		chk1("space flag enable in reset", 1'b0, tx_oe);
		chk8("bus enable in reset", 8'h00, bus_oe);
		tick(1);
		rst = 1'b0;
		tick(6);
		t_mode();
		t_read();
		t_write();
		t_flush();
		t_bitbang();
		wrap_up();
	end
endmodule
